/* hdl/occ_channel.v */
`timescale 1ns/1ps
`include "occ_map.vh"

// Summary of operation
// - Control bit 3 picks timer B over A.
// - Idle stop bit halts channel in CPU idle.
// - Fault status is read-only, hardware cleared, PWM-fault.
// - Modes 000 to 011: off, high, low, toggle.
// - Modes 100 to 111: pulses and PWM variants.
// - Unimplemented control bits always read zero.
// - Match when selected count equals primary value.
// - Toggle mode inverts pin every match, flags each.
// - Mode 001 entry drives pin low.
// - Mode 001 drives pin high after match.
// - Mode 001 flag two clocks after pin rises.
// - Mode 010 entry drives pin high.
// - Mode 010 drives pin low after match.
// - Mode 010 flag two clocks after pin falls.
// - Time base wraps to zero after its period.
// - Low fault input serves channels one to four.
// - Each channel owns its control and compare registers.
// - Toggle entered from off starts low, else keeps its level, flag two clocks after toggle.

module occ_channel #(
  parameter CHANNEL_INDEX = 1
) (
  // Clock and reset.
  input wire CLOCK,
  input wire RST_N,
  // AHB-Lite slave port.
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  // Processor power state.
  input wire CPU_IDLE,
  // Fault inputs, a low level reports a fault.
  input wire FAULT_INPUT_LOW_GROUP_N,
  input wire FAULT_INPUT_HIGH_GROUP_N,
  // Compare output and event.
  output reg COMPARE_OUTPUT_PIN,
  output reg COMPARE_OUTPUT_DRIVE,
  output reg COMPARE_IRQ_FLAG
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  reg [2:0] compare_mode_field;
  reg time_base_select;
  reg idle_stop_bit;
  reg fault_status_bit;
  reg [15:0] primary_compare_value;
  reg [15:0] secondary_compare_value;
  reg [15:0] period_a;
  reg [15:0] period_b;
  reg timer_en_a;
  reg timer_en_b;

  // Bus phase tracking.
  reg wr_pending;
  reg rd_wait;
  reg [7:0] phase_addr;
  reg entry_pending;
  reg [2:0] prev_mode;

  // Channel sequence state.
  reg [2:0] state;
  reg [15:0] pwm_duty;
  reg edge_event;
  reg edge_delay;

  // Time base outputs.
  wire [15:0] tb_count [0:1];
  wire [1:0] tb_wrap;
  wire [1:0] tb_enable;
  wire [15:0] tb_period [0:1];

  ////////////////////////////////////////////////////////////////////////////////
  // Time bases.

  assign tb_enable = {timer_en_b, timer_en_a};
  assign tb_period[0] = period_a;
  assign tb_period[1] = period_b;

  // Two identical time bases, one per selectable timer.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tb
      occ_timebase u_tb (
        .CLOCK(CLOCK),
        .RST_N(RST_N),
        .ENABLE(tb_enable[gi]),
        .PERIOD(tb_period[gi]),
        .COUNT(tb_count[gi]),
        .WRAP(tb_wrap[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Compare decode.

  wire [15:0] selected_timer_count;
  wire selected_run;
  wire selected_wrap;
  wire halted;
  wire match_primary;
  wire match_secondary;
  wire match_duty;
  wire fault_in;

  // Select the time base for this channel.
  assign selected_timer_count = time_base_select ? tb_count[1] : tb_count[0];
  assign selected_run = time_base_select ? timer_en_b : timer_en_a;
  assign selected_wrap = time_base_select ? tb_wrap[1] : tb_wrap[0];

  // The channel freezes in CPU idle only when asked to.
  assign halted = idle_stop_bit && CPU_IDLE;

  // Matches only count while the selected timer advances.
  assign match_primary = selected_run && (selected_timer_count == primary_compare_value);
  assign match_secondary = selected_run && (selected_timer_count == secondary_compare_value);
  assign match_duty = selected_run && (selected_timer_count == pwm_duty);

  // Channels one to four watch the low fault group, the rest the high group.
  assign fault_in = (CHANNEL_INDEX <= `OCC_LAST_LOW_GROUP) ?
                    !FAULT_INPUT_LOW_GROUP_N : !FAULT_INPUT_HIGH_GROUP_N;

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave.

  wire addr_take;
  reg [31:0] read_mux;

  // A transfer is taken on a valid address phase.
  assign addr_take = HSEL && HTRANS[1] && HREADY;
  // Reads insert one wait state so the data comes from a flip-flop.
  assign HREADYOUT = !rd_wait;
  assign HRESP = 1'b0;

  // Readback of every register, unmapped offsets read zero.
  always @* begin
    read_mux = `OCC_RST_32;
    case (phase_addr)
      `OCC_OFF_CTRL: begin
        read_mux[`OCC_MODE_MSB:`OCC_MODE_LSB] = compare_mode_field;
        read_mux[`OCC_TSEL_BIT] = time_base_select;
        read_mux[`OCC_FAULT_BIT] = fault_status_bit;
        read_mux[`OCC_SIDL_BIT] = idle_stop_bit;
      end
      `OCC_OFF_PRIMARY: read_mux[15:0] = primary_compare_value;
      `OCC_OFF_SECONDARY: read_mux[15:0] = secondary_compare_value;
      `OCC_OFF_PERIOD_A: read_mux[15:0] = period_a;
      `OCC_OFF_PERIOD_B: read_mux[15:0] = period_b;
      `OCC_OFF_TIMER_CTRL: begin
        read_mux[`OCC_TEN_A_BIT] = timer_en_a;
        read_mux[`OCC_TEN_B_BIT] = timer_en_b;
      end
      `OCC_OFF_STATUS: begin
        read_mux[`OCC_STAT_PIN_BIT] = COMPARE_OUTPUT_PIN;
        read_mux[`OCC_STAT_DONE_BIT] = state[2];
        read_mux[`OCC_STAT_FAULT_BIT] = fault_status_bit;
      end
      `OCC_OFF_COUNT_A: read_mux[15:0] = tb_count[0];
      `OCC_OFF_COUNT_B: read_mux[15:0] = tb_count[1];
      default: read_mux = `OCC_RST_32;
    endcase
  end

  // Phase tracking and read data register.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pending <= 1'b0;
      rd_wait <= 1'b0;
      phase_addr <= 8'h00;
      HRDATA <= `OCC_RST_32;
    end else begin
      if (rd_wait) begin
        HRDATA <= read_mux;
      end
      rd_wait <= addr_take && !HWRITE;
      wr_pending <= addr_take && HWRITE;
      if (addr_take) begin
        phase_addr <= HADDR[7:0];
      end
    end
  end

  // Register writes land at the end of the data phase.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      compare_mode_field <= `OCC_RST_MODE;
      time_base_select <= 1'b0;
      idle_stop_bit <= 1'b0;
      primary_compare_value <= `OCC_RST_16;
      secondary_compare_value <= `OCC_RST_16;
      period_a <= `OCC_RST_16;
      period_b <= `OCC_RST_16;
      timer_en_a <= 1'b0;
      timer_en_b <= 1'b0;
      entry_pending <= 1'b0;
    end else begin
      entry_pending <= 1'b0;
      if (wr_pending) begin
        case (phase_addr)
          `OCC_OFF_CTRL: begin
            compare_mode_field <= HWDATA[`OCC_MODE_MSB:`OCC_MODE_LSB];
            time_base_select <= HWDATA[`OCC_TSEL_BIT];
            idle_stop_bit <= HWDATA[`OCC_SIDL_BIT];
            entry_pending <= 1'b1;
          end
          `OCC_OFF_PRIMARY: primary_compare_value <= HWDATA[15:0];
          `OCC_OFF_SECONDARY: secondary_compare_value <= HWDATA[15:0];
          `OCC_OFF_PERIOD_A: period_a <= HWDATA[15:0];
          `OCC_OFF_PERIOD_B: period_b <= HWDATA[15:0];
          `OCC_OFF_TIMER_CTRL: begin
            timer_en_a <= HWDATA[`OCC_TEN_A_BIT];
            timer_en_b <= HWDATA[`OCC_TEN_B_BIT];
          end
          default: entry_pending <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fault status.

  // Set by a fault in fault-enabled PWM, cleared by hardware at a clean wrap.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fault_status_bit <= 1'b0;
    end else if (compare_mode_field == `OCC_M_PWM_FAULT && fault_in) begin
      fault_status_bit <= 1'b1;
    end else if (compare_mode_field != `OCC_M_PWM_FAULT || selected_wrap) begin
      fault_status_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel sequencer and output pin.

  // A mode write initialises the pin; later matches move it per mode.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      COMPARE_OUTPUT_PIN <= 1'b0;
      COMPARE_OUTPUT_DRIVE <= 1'b0;
      state <= `OCC_ST_FIRST;
      prev_mode <= `OCC_RST_MODE;
      pwm_duty <= `OCC_RST_16;
      edge_event <= 1'b0;
    end else begin
      edge_event <= 1'b0;
      if (entry_pending) begin
        prev_mode <= compare_mode_field;
        state <= `OCC_ST_FIRST;
        COMPARE_OUTPUT_DRIVE <= (compare_mode_field != `OCC_M_OFF);
        pwm_duty <= secondary_compare_value;
        case (compare_mode_field)
          `OCC_M_OFF: COMPARE_OUTPUT_PIN <= 1'b0;
          `OCC_M_SET_HIGH: COMPARE_OUTPUT_PIN <= 1'b0;
          `OCC_M_SET_LOW: COMPARE_OUTPUT_PIN <= 1'b1;
          `OCC_M_TOGGLE: begin
            // Coming from off the pin starts low, else it keeps its level.
            if (prev_mode == `OCC_M_OFF) begin
              COMPARE_OUTPUT_PIN <= 1'b0;
            end
          end
          default: COMPARE_OUTPUT_PIN <= 1'b0;
        endcase
      end else if (!halted) begin
        case (compare_mode_field)
          `OCC_M_SET_HIGH: begin
            if (match_primary && state == `OCC_ST_FIRST) begin
              COMPARE_OUTPUT_PIN <= 1'b1;
              state <= `OCC_ST_DONE;
              edge_event <= 1'b1;
            end
          end
          `OCC_M_SET_LOW: begin
            if (match_primary && state == `OCC_ST_FIRST) begin
              COMPARE_OUTPUT_PIN <= 1'b0;
              state <= `OCC_ST_DONE;
              edge_event <= 1'b1;
            end
          end
          `OCC_M_TOGGLE: begin
            if (match_primary) begin
              COMPARE_OUTPUT_PIN <= !COMPARE_OUTPUT_PIN;
              edge_event <= 1'b1;
            end
          end
          `OCC_M_ONE_PULSE, `OCC_M_PULSES: begin
            // Rise on the primary match, fall on the secondary match.
            case (state)
              `OCC_ST_FIRST: begin
                if (match_primary) begin
                  COMPARE_OUTPUT_PIN <= 1'b1;
                  state <= `OCC_ST_SECOND;
                end
              end
              `OCC_ST_SECOND: begin
                if (match_secondary) begin
                  COMPARE_OUTPUT_PIN <= 1'b0;
                  edge_event <= 1'b1;
                  if (compare_mode_field == `OCC_M_PULSES) begin
                    state <= `OCC_ST_FIRST;
                  end else begin
                    state <= `OCC_ST_DONE;
                  end
                end
              end
              `OCC_ST_DONE: state <= `OCC_ST_DONE;
              default: state <= `OCC_ST_FIRST;
            endcase
          end
          `OCC_M_PWM, `OCC_M_PWM_FAULT: begin
            // Period start raises the pin, the buffered duty lowers it.
            if (compare_mode_field == `OCC_M_PWM_FAULT && (fault_in || fault_status_bit)) begin
              COMPARE_OUTPUT_PIN <= 1'b0;
            end else if (selected_wrap) begin
              pwm_duty <= secondary_compare_value;
              COMPARE_OUTPUT_PIN <= (secondary_compare_value != `OCC_RST_16);
              edge_event <= 1'b1;
            end else if (match_duty) begin
              COMPARE_OUTPUT_PIN <= 1'b0;
            end
          end
          default: state <= state;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flag delay.

  // The flag pulses two clocks after the pin edge that caused it.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      edge_delay <= 1'b0;
      COMPARE_IRQ_FLAG <= 1'b0;
    end else begin
      edge_delay <= edge_event;
      COMPARE_IRQ_FLAG <= edge_delay;
    end
  end

endmodule

/* hdl/occ_map.vh */
`ifndef OCC_MAP_VH
`define OCC_MAP_VH

// Register byte offsets on the AHB-Lite port.
`define OCC_ADDR_W 8
`define OCC_OFF_CTRL 8'h00
`define OCC_OFF_PRIMARY 8'h04
`define OCC_OFF_SECONDARY 8'h08
`define OCC_OFF_PERIOD_A 8'h0C
`define OCC_OFF_PERIOD_B 8'h10
`define OCC_OFF_TIMER_CTRL 8'h14
`define OCC_OFF_STATUS 8'h18
`define OCC_OFF_COUNT_A 8'h1C
`define OCC_OFF_COUNT_B 8'h20

// Control register fields.
`define OCC_MODE_MSB 2
`define OCC_MODE_LSB 0
`define OCC_TSEL_BIT 3
`define OCC_FAULT_BIT 4
`define OCC_SIDL_BIT 13

// Status register fields.
`define OCC_STAT_PIN_BIT 0
`define OCC_STAT_DONE_BIT 1
`define OCC_STAT_FAULT_BIT 2

// Timer control register fields.
`define OCC_TEN_A_BIT 0
`define OCC_TEN_B_BIT 1

// Reset values.
`define OCC_RST_16 16'h0000
`define OCC_RST_32 32'h00000000
`define OCC_RST_MODE 3'h0

// Compare mode encodings.
`define OCC_M_OFF 3'h0
`define OCC_M_SET_HIGH 3'h1
`define OCC_M_SET_LOW 3'h2
`define OCC_M_TOGGLE 3'h3
`define OCC_M_ONE_PULSE 3'h4
`define OCC_M_PULSES 3'h5
`define OCC_M_PWM 3'h6
`define OCC_M_PWM_FAULT 3'h7

// One-hot channel sequence states.
`define OCC_ST_FIRST 3'h1
`define OCC_ST_SECOND 3'h2
`define OCC_ST_DONE 3'h4

// Channel numbering and fault grouping.
`define OCC_LAST_LOW_GROUP 4

`endif

/* hdl/occ_timebase.v */
`timescale 1ns/1ps
`include "occ_map.vh"

module occ_timebase (
  // Clock and reset.
  input wire CLOCK,
  input wire RST_N,
  // Control.
  input wire ENABLE,
  input wire [15:0] PERIOD,
  // Count state.
  output reg [15:0] COUNT,
  output wire WRAP
);

  // The count has reached its period and returns to zero next.
  assign WRAP = ENABLE && (COUNT == PERIOD);

  // Counts up while enabled and restarts from zero after the period.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      COUNT <= `OCC_RST_16;
    end else if (WRAP) begin
      COUNT <= `OCC_RST_16;
    end else if (ENABLE) begin
      COUNT <= COUNT + 16'h0001;
    end
  end

endmodule

/* test/occ_channel_chk.sv */
`timescale 1ns/1ps
module occ_channel_chk (
  // Clock and reset.
  input wire CLOCK,
  input wire RST_N,
  // Bus handshake.
  input wire HSEL,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire HREADYOUT,
  input wire HRESP,
  // Compare output.
  input wire COMPARE_OUTPUT_PIN,
  input wire COMPARE_OUTPUT_DRIVE,
  input wire COMPARE_IRQ_FLAG
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // A transfer is taken when selected, active and ready.
  wire take = HSEL && HTRANS[1] && HREADY;
  ////////////////////////////////////////
  // Bus timing and compare event checks.
  bus_okay_a: assert property (HRESP == 1'b0)
    else $error("Bus response not OKAY.");
  write_no_wait_a: assert property (take && HWRITE |=> HREADYOUT)
    else $error("Write data phase stalled.");
  read_one_wait_a: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("Read data phase not one wait state.");
  flag_after_edge_a: assert property (
    COMPARE_IRQ_FLAG |-> $past(COMPARE_OUTPUT_PIN, 2) != $past(COMPARE_OUTPUT_PIN, 3))
    else $error("Event flag not two clocks after pin change.");
  flag_one_cycle_a: assert property (COMPARE_IRQ_FLAG |=> !COMPARE_IRQ_FLAG)
    else $error("Event flag longer than one cycle.");
  off_pin_low_a: assert property (!COMPARE_OUTPUT_DRIVE |-> !COMPARE_OUTPUT_PIN)
    else $error("Disabled channel pin not low.");
  pin_needs_mode_a: assert property (
    $changed(COMPARE_OUTPUT_PIN) |-> COMPARE_OUTPUT_DRIVE || $past(COMPARE_OUTPUT_DRIVE))
    else $error("Pin moved while channel disabled.");
  reset_quiet_a: assert property (
    $rose(RST_N) |-> !COMPARE_OUTPUT_PIN && !COMPARE_IRQ_FLAG && HREADYOUT)
    else $error("Outputs not quiet after reset.");
  // Main scenarios seen.
  cover property (COMPARE_IRQ_FLAG);
  cover property (take && !HWRITE);
  cover property ($rose(COMPARE_OUTPUT_PIN) && COMPARE_OUTPUT_DRIVE);
endmodule

bind occ_channel occ_channel_chk chk (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN),
  .COMPARE_OUTPUT_DRIVE(COMPARE_OUTPUT_DRIVE), .COMPARE_IRQ_FLAG(COMPARE_IRQ_FLAG));

/* test/occ_pin_load.sv */
`timescale 1ns/1ps
module occ_pin_load (
  // Clock.
  input wire clock,
  // Observed pin and event.
  input wire pin,
  input wire drive,
  input wire flag,
  // Running tallies.
  output reg [31:0] edge_count,
  output reg [31:0] flag_count
);
  reg last_pin;
  // Tallies start empty.
  initial begin
    edge_count = 32'h0;
    flag_count = 32'h0;
    last_pin = 1'b0;
  end
  // Counts driven pin changes and event pulses seen by the load.
  always @(posedge clock) begin
    last_pin <= pin;
    if (drive === 1'b1 && pin !== last_pin) begin
      edge_count <= edge_count + 32'h1;
    end
    if (flag === 1'b1) begin
      flag_count <= flag_count + 32'h1;
    end
  end
endmodule

/* test/occ_channel_bench.sv */
`timescale 1ns/1ps
`include "occ_map.vh"
module occ_channel_bench;
  reg clock;
  reg rst_n;
  reg hsel;
  reg [31:0] haddr;
  reg [1:0] htrans;
  reg hwrite;
  reg [31:0] hwdata;
  reg cpu_idle;
  reg fault_low_n;
  reg fault_high_n;
  wire [31:0] hrdata;
  wire hreadyout;
  wire pin;
  wire drive;
  wire flag;
  wire [31:0] edges;
  wire [31:0] flags;
  integer bad_count;
  integer checked;
  integer m;
  reg [31:0] rd;
  reg [31:0] e0;
  ////////////////////////////////////////
  // Device, its pin load and the clock.
  occ_channel dut (.CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .CPU_IDLE(cpu_idle),
    .FAULT_INPUT_LOW_GROUP_N(fault_low_n), .FAULT_INPUT_HIGH_GROUP_N(fault_high_n),
    .COMPARE_OUTPUT_PIN(pin), .COMPARE_OUTPUT_DRIVE(drive), .COMPARE_IRQ_FLAG(flag));
  occ_pin_load load (.clock(clock), .pin(pin), .drive(drive), .flag(flag),
    .edge_count(edges), .flag_count(flags));
  // Free-running 250 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ////////////////////////////////////////
  // Reporting and bus tasks.
  task print_verdict;
    begin
      if (bad_count == 0 && checked > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wait_ready;
    integer n;
    begin
      n = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clock);
      end
      if (n >= 50) begin
        bad_count = bad_count + 1;
        print_verdict;
      end
    end
  endtask
  task bus_write(input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
    end
  endtask
  task bus_read(input [7:0] a, output [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      wait_ready;
      htrans <= 2'h0;
      wait_ready;
      d = hrdata;
    end
  endtask
  task run(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // Waits a bounded time for the pin to move.
  task wait_pin;
    integer n;
    reg p;
    begin
      p = pin;
      n = 0;
      while (pin === p && n < 60) begin
        n = n + 1;
        @(posedge clock);
      end
      if (n >= 60) begin
        bad_count = bad_count + 1;
        print_verdict;
      end
    end
  endtask
  ////////////////////////////////////////
  // Main sequence.
  initial begin
    bad_count = 0;
    checked = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cpu_idle = 1'b0;
    fault_low_n = 1'b1;
    fault_high_n = 1'b1;
    run(10);
    rst_n <= 1'b1;
    run(1);
    check("reset outputs", {hreadyout, drive, pin, flag}, 4'h8);
    bus_read(`OCC_OFF_CTRL, rd);
    check("ctrl reset", rd, 32'h0);
    bus_read(8'h40, rd);
    check("unmapped", rd, 32'h0);
    bus_write(`OCC_OFF_CTRL, 32'hFFFF);
    bus_read(`OCC_OFF_CTRL, rd);
    check("ctrl mask", rd, 32'h200F);
    // Every mode code, entered from the disabled state.
    for (m = 0; m < 8; m = m + 1) begin
      bus_write(`OCC_OFF_CTRL, 32'h0);
      bus_write(`OCC_OFF_CTRL, m);
      run(2);
      bus_read(`OCC_OFF_CTRL, rd);
      check("mode", rd, m);
      check("drive", drive, m != 0);
      if (m < 6) check("entry pin", pin, m == 2);
    end
    // Set-high mode on time base A.
    bus_write(`OCC_OFF_CTRL, 32'h0);
    bus_write(`OCC_OFF_PERIOD_A, 32'd20);
    bus_write(`OCC_OFF_PRIMARY, 32'd5);
    bus_write(`OCC_OFF_CTRL, 32'h1);
    e0 = flags;
    bus_write(`OCC_OFF_TIMER_CTRL, 32'h1);
    wait_pin;
    check("set high", pin, 1'b1);
    run(4);
    check("set flag", flags - e0, 32'h1);
    run(50);
    check("one shot pin", pin, 1'b1);
    check("one shot flag", flags - e0, 32'h1);
    bus_read(`OCC_OFF_COUNT_A, rd);
    check("count range", rd > 32'd20, 1'b0);
    // Set-low mode waits for time base B.
    bus_write(`OCC_OFF_CTRL, 32'h0);
    bus_write(`OCC_OFF_PERIOD_B, 32'd20);
    bus_write(`OCC_OFF_CTRL, 32'hA);
    run(60);
    check("tb select", pin, 1'b1);
    e0 = flags;
    bus_write(`OCC_OFF_TIMER_CTRL, 32'h3);
    wait_pin;
    check("set low", pin, 1'b0);
    run(4);
    check("low flag", flags - e0, 32'h1);
    // Toggle mode flags every match.
    bus_write(`OCC_OFF_CTRL, 32'h0);
    bus_write(`OCC_OFF_CTRL, 32'h3);
    run(2);
    check("toggle start", pin, 1'b0);
    for (m = 0; m < 3; m = m + 1) begin
      e0 = flags;
      wait_pin;
      run(4);
      check("toggle flag", flags - e0, 32'h1);
    end
    // Idle stop halts, idle run continues.
    cpu_idle <= 1'b1;
    bus_write(`OCC_OFF_CTRL, 32'h2003);
    e0 = edges;
    run(60);
    check("idle halt", edges - e0, 32'h0);
    bus_write(`OCC_OFF_CTRL, 32'h3);
    e0 = flags;
    wait_pin;
    run(4);
    check("idle run", flags - e0, 32'h1);
    // Fault grouping and the hardware-cleared fault status, timers stopped.
    bus_write(`OCC_OFF_TIMER_CTRL, 32'h0);
    bus_write(`OCC_OFF_CTRL, 32'h0);
    bus_write(`OCC_OFF_CTRL, 32'h7);
    fault_high_n <= 1'b0;
    run(3);
    bus_read(`OCC_OFF_CTRL, rd);
    check("other group", rd, 32'h7);
    fault_low_n <= 1'b0;
    run(3);
    bus_read(`OCC_OFF_CTRL, rd);
    check("fault set", rd, 32'h17);
    check("fault pin", pin, 1'b0);
    fault_low_n <= 1'b1;
    fault_high_n <= 1'b1;
    bus_write(`OCC_OFF_CTRL, 32'h7);
    bus_read(`OCC_OFF_CTRL, rd);
    check("fault held", rd, 32'h17);
    bus_write(`OCC_OFF_CTRL, 32'h0);
    bus_read(`OCC_OFF_CTRL, rd);
    check("fault cleared", rd, 32'h0);
    print_verdict;
  end
endmodule
